// ---- logic/csc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csc_defines.svh"
// Summary of operation
// R1: search word width one to eight bits
// R2: don't-care and hidden channels never compared
// R3: match marker at matching data locations
// R4: search reports count, first, next, last
// R5: search step moves cursor, advances next
// R6: cursor zero after reset or recording
// R7: step once per press, repeat while held
// R8: jump digits load cursor on enter
// R9: view scrolls a twenty-location column
// R10: operator picks polarity before recording
// R11: capture memory runs, freezes on trigger
// R12: frozen record copied to display automatically
// R13: copy display to reference; host loads reference
// R14: compare flags differing locations, shows data
// R15: autostop re-arms while all locations match
// R16: autostop halts on any mismatch
// R17: reference controls from panel and bus
// R18: operator should record synchronously to compare
// R19: memories two thousand words, cursor spans all
// R20: match needs every cared bit equal
module csc_top #(
  parameter int DEPTH    = `CSC_DEPTH,
  parameter int WIDTH    = `CSC_WIDTH,
  parameter int AW       = 11,
  parameter int COL      = `CSC_COL_LEN,
  parameter int HOLD_CYC = `CSC_HOLD_CYC,
  parameter int RPT_CYC  = `CSC_RPT_CYC
) (
  input  wire logic               pclk,         // apb clock
  input  wire logic               presetn,      // async reset, low
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb enable
  input  wire logic               pwrite,       // apb direction
  input  wire logic [7:0]         paddr,        // apb byte address
  input  wire logic [31:0]        pwdata,       // apb write data
  output var  logic [31:0]        prdata,       // apb read data
  output var  logic               pready,       // apb ready
  output var  logic               pslverr,      // apb error
  input  wire logic [WIDTH-1:0]   sample_in,    // probe samples
  input  wire logic               sample_valid, // sample strobe
  input  wire logic               trigger,      // trigger event
  input  wire csc_pkg::csc_keys_t keys,         // panel keys
  output var  logic [AW-1:0]      cursor_o,     // cursor address
  output var  logic [AW-1:0]      view_base_o,  // head of left column
  output var  csc_pkg::csc_view_t view_o,       // word at cursor
  output var  logic               recording_o,  // capture running
  output var  logic               stopped_mm_o  // autostop halted
);
  localparam logic [AW-1:0] LAST_A = AW'(DEPTH - 1);
  localparam logic [AW:0]   COL_W  = (AW+1)'(COL);

  csc_pkg::csc_state_t state_r, state_nxt; // engine state
  csc_pkg::csc_keys_t  keys_q_r, key_rise; // key edge detect
  csc_pkg::csc_view_t  view_r;             // view register
  logic [2:0]       ctrl_r;                // inv, compare, autostop
  logic [31:0]      srch_r;                // search word setup
  logic [AW-1:0]    wptr_r, rptr_r;        // capture write, copy read
  logic [AW-1:0]    scan_r, scan_d_r;      // scan address, delayed
  logic [AW-1:0]    cursor_r, base_r;      // cursor and view head
  logic [AW-1:0]    count_r, first_r;      // search results
  logic [AW-1:0]    next_r, last_r;        // search results
  logic [AW-1:0]    n1_r, n2_r;            // candidates after cursor
  logic             n1f_r, n2f_r;          // candidate found
  logic             full_r, iss_done_r;    // capture wrapped, scan issued
  logic             rdv_r, fin_r, smode_r; // read valid, search done, step mode
  logic             mism_r, stop_mm_r;     // mismatch seen, autostop halt
  logic             rec_r;                 // recording flag
  logic [13:0]      acc_r;                 // jump digit accumulator
  logic [31:0]      hold_r;                // key hold counter
  logic             pready_r, pslverr_r;   // apb answer
  logic [31:0]      prdata_r, rd_nxt;      // apb read data
  logic             rd_bad;                // unmapped address
  logic [WIDTH-1:0] m_rdata, a_rdata, b_rdata;

  // compares one word to the search setup
  function automatic logic hit(input logic [WIDTH-1:0] w, input logic [31:0] s);
    logic [WIDTH-1:0] care;
    care = ~({WIDTH{1'b1}} << ({1'b0, s[`CSC_SW_WSEL +: 3]} + 4'd1)); // R1
    care = care & ~s[`CSC_SW_DC +: WIDTH] & s[`CSC_SW_CHEN +: WIDTH];  // R2
    return ((w ^ s[`CSC_SW_WORD +: WIDTH]) & care) == '0;              // R20
  endfunction : hit

  // address plus one, wrapping at the memory end
  function automatic logic [AW-1:0] inc(input logic [AW-1:0] a);
    return (a == LAST_A) ? '0 : AW'(a + 1'b1); // R19
  endfunction : inc

  wire        idle     = state_r == csc_pkg::ST_IDLE;
  wire        capt     = state_r == csc_pkg::ST_CAPT;
  wire        scanning = !idle && !capt;
  wire        iss      = scanning && !iss_done_r;
  wire        scan_end = rdv_r && scan_d_r == LAST_A;
  wire        apb_wr   = psel && penable && pwrite && pready_r;
  wire [31:0] bus_cmd  = (apb_wr && paddr == `CSC_CMD) ? pwdata : 32'h0000_0000;
  wire        hit_now  = rdv_r && hit(a_rdata, srch_r);
  wire        diff_now = rdv_r && a_rdata != b_rdata;
  wire        tick     = (keys.step_up || keys.step_dn) && hold_r == 32'(HOLD_CYC - 1);
  wire        go_arm   = bus_cmd[`CSC_CMD_ARM] || key_rise.arm;
  wire        go_srch  = bus_cmd[`CSC_CMD_SRCH] || key_rise.search;
  wire        go_step  = bus_cmd[`CSC_CMD_STEP] || key_rise.search_step;
  wire        go_copy  = bus_cmd[`CSC_CMD_COPY] || key_rise.copy;
  wire        go_enter = bus_cmd[`CSC_CMD_ENTER] || key_rise.enter_key;
  wire        go_up    = bus_cmd[`CSC_CMD_UP] || key_rise.step_up || (tick && keys.step_up);
  wire        go_dn    = bus_cmd[`CSC_CMD_DN] || key_rise.step_dn || (tick && keys.step_dn);
  wire        bus_dig  = apb_wr && paddr == `CSC_DIGIT;
  wire        go_dig   = bus_dig || key_rise.digit_valid;
  wire [3:0]  dig_val  = bus_dig ? pwdata[3:0] : keys.digit;
  wire        xfer_end = state_r == csc_pkg::ST_XFER && scan_end;
  wire        cmp_end  = state_r == csc_pkg::ST_CMPR && scan_end;
  wire        mm_all   = mism_r || diff_now;
  wire        rearm    = cmp_end && ctrl_r[`CSC_CTRL_AUTO] && !mm_all;
  wire        arm_now  = (idle && go_arm) || rearm;
  wire        srch_go  = idle && (go_srch || go_step);
  wire [AW-1:0] n1_eff = n1f_r ? n1_r : first_r;   // wraps to first
  wire [AW-1:0] n2_eff = n2f_r ? n2_r : first_r;
  wire [AW-1:0] jump_a = (acc_r > 14'(DEPTH - 1)) ? LAST_A : AW'(acc_r);

  // memory ports
  wire          m_we    = capt && sample_valid && !trigger;                  // R11
  wire          a_we    = state_r == csc_pkg::ST_XFER && rdv_r;              // R12
  wire          cp_we   = state_r == csc_pkg::ST_COPY && rdv_r;              // R13
  wire          ld_we   = apb_wr && paddr == `CSC_REFLD && state_r != csc_pkg::ST_COPY;
  wire          b_we    = cp_we || ld_we;                                    // R13
  wire [AW-1:0] b_waddr = cp_we ? scan_d_r : pwdata[`CSC_RL_ADDR +: AW];
  wire [WIDTH-1:0] b_wdata = cp_we ? a_rdata : pwdata[`CSC_RL_DATA +: WIDTH];
  wire [AW-1:0] rd_addr = scanning ? scan_r : cursor_r;
  wire [WIDTH-1:0] m_wdata = sample_in ^ {WIDTH{ctrl_r[`CSC_CTRL_INV]}};     // R10

  csc_mem #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) u_mem_cap (
    .clk(pclk), .we(m_we), .waddr(wptr_r), .wdata(m_wdata),
    .raddr(rptr_r), .rdata(m_rdata));
  csc_mem #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) u_mem_disp (
    .clk(pclk), .we(a_we), .waddr(scan_d_r), .wdata(m_rdata),
    .raddr(rd_addr), .rdata(a_rdata));
  csc_mem #(.DEPTH(DEPTH), .WIDTH(WIDTH), .AW(AW)) u_mem_ref (
    .clk(pclk), .we(b_we), .waddr(b_waddr), .wdata(b_wdata),
    .raddr(rd_addr), .rdata(b_rdata));

  // engine sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      csc_pkg::ST_IDLE: begin
        if (go_arm) state_nxt = csc_pkg::ST_CAPT;
        else if (go_srch || go_step) state_nxt = csc_pkg::ST_SRCH;
        else if (go_copy) state_nxt = csc_pkg::ST_COPY;              // R13
      end
      csc_pkg::ST_CAPT: begin
        if (trigger) state_nxt = csc_pkg::ST_XFER;                   // R11
      end
      csc_pkg::ST_XFER: begin
        if (scan_end) begin                                          // R12
          state_nxt = (ctrl_r[`CSC_CTRL_AUTO] || ctrl_r[`CSC_CTRL_CMP]) ?
                      csc_pkg::ST_CMPR : csc_pkg::ST_IDLE;
        end
      end
      csc_pkg::ST_CMPR: begin
        // autostop loops until a difference shows up
        if (scan_end) state_nxt = rearm ? csc_pkg::ST_CAPT : csc_pkg::ST_IDLE; // R15 R16
      end
      csc_pkg::ST_SRCH, csc_pkg::ST_COPY: begin
        if (scan_end) state_nxt = csc_pkg::ST_IDLE;
      end
    endcase
  end

  // state register and recording flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= csc_pkg::ST_IDLE;
      rec_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rec_r   <= state_nxt == csc_pkg::ST_CAPT;
    end
  end

  // scan address generator, shared by every pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_r     <= '0;
      scan_d_r   <= '0;
      iss_done_r <= 1'b0;
      rdv_r      <= 1'b0;
    end else begin
      rdv_r    <= iss;
      scan_d_r <= scan_r;
      if (!scanning || scan_end) begin
        scan_r     <= '0;
        iss_done_r <= 1'b0;
      end else if (iss) begin
        scan_r <= inc(scan_r);
        if (scan_r == LAST_A) iss_done_r <= 1'b1;
      end
    end
  end

  // capture memory pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= '0;
      full_r <= 1'b0;
      rptr_r <= '0;
    end else if (arm_now) begin
      wptr_r <= '0;
      full_r <= 1'b0;
    end else if (capt && trigger) begin
      rptr_r <= full_r ? wptr_r : '0;   // oldest sample first
    end else if (m_we) begin
      wptr_r <= inc(wptr_r);            // R11
      if (wptr_r == LAST_A) full_r <= 1'b1;
    end else if (state_r == csc_pkg::ST_XFER && iss) begin
      rptr_r <= inc(rptr_r);
    end
  end

  // compare pass and autostop halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mism_r    <= 1'b0;
      stop_mm_r <= 1'b0;
    end else begin
      if (xfer_end) mism_r <= 1'b0;
      else if (state_r == csc_pkg::ST_CMPR && diff_now) mism_r <= 1'b1; // R14
      if (arm_now) stop_mm_r <= 1'b0;
      else if (cmp_end && ctrl_r[`CSC_CTRL_AUTO] && mm_all) stop_mm_r <= 1'b1; // R16
    end
  end

  // search pass bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      first_r <= '0;
      last_r  <= '0;
      n1_r    <= '0;
      n2_r    <= '0;
      n1f_r   <= 1'b0;
      n2f_r   <= 1'b0;
      smode_r <= 1'b0;
      fin_r   <= 1'b0;
    end else begin
      fin_r <= state_r == csc_pkg::ST_SRCH && scan_end;
      if (srch_go) begin
        count_r <= '0;
        n1f_r   <= 1'b0;
        n2f_r   <= 1'b0;
        smode_r <= !go_srch;           // step keeps the cursor
      end else if (state_r == csc_pkg::ST_SRCH && hit_now) begin
        count_r <= AW'(count_r + 1'b1);                        // R4
        if (count_r == '0) first_r <= scan_d_r;
        last_r <= scan_d_r;
        if (scan_d_r > cursor_r && !n1f_r) begin
          n1_r  <= scan_d_r;
          n1f_r <= 1'b1;
        end else if (scan_d_r > cursor_r && !n2f_r) begin
          n2_r  <= scan_d_r;
          n2f_r <= 1'b1;
        end
      end
    end
  end

  // next-match pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_r <= '0;
    end else if (fin_r && count_r != '0) begin
      next_r <= smode_r ? n1_eff : n2_eff;                     // R4 R5
    end
  end

  // cursor movement, one source at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_r <= '0;                                          // R6
    end else if (xfer_end) begin
      cursor_r <= '0;                                          // R6
    end else if (fin_r && count_r != '0 && !smode_r) begin
      cursor_r <= n1_eff;                                      // R4
    end else if (idle && go_step) begin
      if (count_r != '0) cursor_r <= next_r;                   // R5
    end else if (!scanning && go_enter) begin
      cursor_r <= jump_a;                                      // R8
    end else if (!scanning && go_up) begin
      cursor_r <= inc(cursor_r);                               // R7
    end else if (!scanning && go_dn) begin
      cursor_r <= (cursor_r == '0) ? LAST_A : AW'(cursor_r - 1'b1); // R7
    end
  end

  // column scroll keeps the cursor in the left column
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= '0;
    end else if ({1'b0, cursor_r} >= {1'b0, base_r} + COL_W) begin
      base_r <= AW'({1'b0, base_r} + COL_W);                   // R9
    end else if (cursor_r < base_r) begin
      base_r <= AW'({1'b0, base_r} - COL_W);                   // R9
    end
  end

  // jump entry; digits only count, enter loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (!scanning && go_enter) begin
      acc_r <= '0;                                             // R8
    end else if (go_dig && dig_val <= 4'h9) begin
      acc_r <= 14'(acc_r * 14'd10 + 14'(dig_val));             // R8
    end
  end

  // held step key: wait, then repeat slowly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r   <= '0;
      keys_q_r <= '0;
    end else begin
      keys_q_r <= keys;
      if (!(keys.step_up || keys.step_dn)) hold_r <= '0;
      else if (tick) hold_r <= 32'(HOLD_CYC - RPT_CYC);        // R7
      else hold_r <= hold_r + 32'h0000_0001;
    end
  end
  assign key_rise = keys & ~keys_q_r;

  // control from bus or panel, search setup from bus only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CSC_CTRL_RST;
      srch_r <= `CSC_SRCH_RST;
    end else begin
      if (apb_wr && paddr == `CSC_CTRL) ctrl_r <= pwdata[2:0];  // R17
      else begin
        if (key_rise.compare) ctrl_r[`CSC_CTRL_CMP] <= !ctrl_r[`CSC_CTRL_CMP];   // R17
        if (key_rise.autostop) ctrl_r[`CSC_CTRL_AUTO] <= !ctrl_r[`CSC_CTRL_AUTO]; // R17
      end
      if (apb_wr && paddr == `CSC_SRCH) srch_r <= pwdata;
    end
  end

  // data view; held still while a pass owns the read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      view_r <= '0;
    end else if (!scanning) begin
      view_r.data     <= a_rdata;                              // R14
      view_r.match    <= hit(a_rdata, srch_r);                 // R3
      view_r.mismatch <= ctrl_r[`CSC_CTRL_CMP] && a_rdata != b_rdata; // R14
    end
  end

  // apb read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_bad = 1'b0;
    unique case (paddr)
      `CSC_CTRL:  rd_nxt = {29'h0, ctrl_r};
      `CSC_SRCH:  rd_nxt = srch_r;
      `CSC_CURS:  rd_nxt = 32'(cursor_r);
      `CSC_COUNT: rd_nxt = 32'(count_r);
      `CSC_PTRS:  rd_nxt = (32'(next_r) << `CSC_PTR_NEXT) | 32'(first_r);
      `CSC_LAST:  rd_nxt = 32'(last_r);
      `CSC_STAT:  rd_nxt = {26'h0, rec_r, stop_mm_r, full_r, state_r};
      `CSC_VIEW:  rd_nxt = 32'(view_r);
      `CSC_CMD, `CSC_DIGIT, `CSC_REFLD: rd_nxt = 32'h0000_0000;
      default:    rd_bad = 1'b1;
    endcase
  end

  // apb answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && rd_bad;
      prdata_r  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign cursor_o     = cursor_r;
  assign view_base_o  = base_r;
  assign view_o       = view_r;
  assign recording_o  = rec_r;
  assign stopped_mm_o = stop_mm_r;

  freeze_cap_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    capt && trigger |-> !m_we ##1 state_r == csc_pkg::ST_XFER)
    else $error("capture did not freeze on trigger");
  auto_xfer_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    capt && trigger |-> ##2 a_we && scan_d_r == '0)
    else $error("display transfer did not start at location zero");
  cursor_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    xfer_end |=> cursor_r == '0)
    else $error("cursor not zero after recording");
  copy_ref_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    cp_we |-> b_we && b_wdata == a_rdata && b_waddr == scan_d_r)
    else $error("reference copy wrote wrong word");
  rearm_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    cmp_end && ctrl_r[`CSC_CTRL_AUTO] && !mm_all |=> capt && !stop_mm_r)
    else $error("autostop did not re-arm on full match");
  stop_mm_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    cmp_end && ctrl_r[`CSC_CTRL_AUTO] && mm_all |=> idle && stop_mm_r ##1 !rec_r)
    else $error("autostop did not halt on mismatch");
  step_one_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    idle && !xfer_end && !fin_r && bus_cmd[`CSC_CMD_UP] && !go_step && !go_enter
    |=> cursor_r == inc($past(cursor_r)))
    else $error("cursor step not one location");
  jump_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    go_dig && !go_enter |=> cursor_r == $past(cursor_r) || $past(go_up || go_dn))
    else $error("cursor moved on a digit");
  col_scroll_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    {1'b0, cursor_r} >= {1'b0, base_r} + COL_W |=> base_r == AW'($past(base_r) + COL))
    else $error("view did not scroll one column");
  srch_place_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    fin_r && count_r != '0 && !smode_r |=> cursor_r == $past(n1_eff) && next_r == $past(n2_eff))
    else $error("search did not place cursor at next match");
endmodule : csc_top
`default_nettype wire

// ---- logic/csc_defines.svh ----
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH
// memory shape
`define CSC_DEPTH     2000
`define CSC_WIDTH     8
`define CSC_COL_LEN   20
// register byte offsets
`define CSC_CTRL      8'h00
`define CSC_CMD       8'h04
`define CSC_SRCH      8'h08
`define CSC_DIGIT     8'h0c
`define CSC_CURS      8'h10
`define CSC_COUNT     8'h14
`define CSC_PTRS      8'h18
`define CSC_LAST      8'h1c
`define CSC_STAT      8'h20
`define CSC_REFLD     8'h24
`define CSC_VIEW      8'h28
// ctrl fields
`define CSC_CTRL_INV  0
`define CSC_CTRL_CMP  1
`define CSC_CTRL_AUTO 2
`define CSC_CTRL_RST  3'h0
// command fields
`define CSC_CMD_ARM   0
`define CSC_CMD_SRCH  1
`define CSC_CMD_STEP  2
`define CSC_CMD_COPY  3
`define CSC_CMD_ENTER 4
`define CSC_CMD_UP    5
`define CSC_CMD_DN    6
// search word fields: word, don't-care, width-1, channel enable
`define CSC_SW_WORD   0
`define CSC_SW_DC     8
`define CSC_SW_WSEL   16
`define CSC_SW_CHEN   24
`define CSC_SRCH_RST  32'hff07_0000
// ref load fields, and next field of ptrs
`define CSC_RL_DATA   0
`define CSC_RL_ADDR   16
`define CSC_PTR_NEXT  16
// key timing
`define CSC_CLK_HZ    40000000
`define CSC_HOLD_MS   400
`define CSC_RPT_MS    100
`define CSC_HOLD_CYC  (`CSC_HOLD_MS * (`CSC_CLK_HZ / 1000))
`define CSC_RPT_CYC   (`CSC_RPT_MS * (`CSC_CLK_HZ / 1000))
`endif

// ---- logic/csc_pkg.sv ----
`include "csc_defines.svh"
package csc_pkg;
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CAPT, ST_XFER, ST_CMPR, ST_SRCH, ST_COPY
  } csc_state_t;

  // front panel keys, all levels
  typedef struct packed {
    logic       arm;
    logic       step_up;
    logic       step_dn;
    logic       search;
    logic       search_step;
    logic       copy;
    logic       enter_key;
    logic       compare;
    logic       autostop;
    logic       digit_valid;
    logic [3:0] digit;
  } csc_keys_t;

  // data view at the cursor
  typedef struct packed {
    logic [`CSC_WIDTH-1:0] data;
    logic                  match;
    logic                  mismatch;
  } csc_view_t;
endpackage : csc_pkg

// ---- logic/csc_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// one write port, registered read port
module csc_mem #(
  parameter int DEPTH = 2000,
  parameter int WIDTH = 8,
  parameter int AW    = 11
) (
  input  wire logic             clk,   // clock
  input  wire logic             we,    // write strobe
  input  wire logic [AW-1:0]    waddr, // write address
  input  wire logic [WIDTH-1:0] wdata, // write data
  input  wire logic [AW-1:0]    raddr, // read address
  output var  logic [WIDTH-1:0] rdata  // read data, one cycle later
);
  logic [WIDTH-1:0] mem [DEPTH];  // no reset, keeps it a plain ram

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : csc_mem
`default_nettype wire

// ---- tb/csc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// probe side: mod-16 ramp restarted on every recording, trigger after 2100 samples
module csc_src_model (
  input  wire logic       pclk, // clock
  input  wire logic       rec,  // device is recording
  output var  logic [7:0] smp,  // sample word
  output var  logic       vld,  // sample strobe
  output var  logic       trg   // trigger
);
  logic [11:0] cnt; // samples since arm
  // restart keeps every record identical, so compares line up
  always_ff @(posedge pclk) cnt <= rec ? cnt + 12'h001 : 12'h000;
  // outside a recording the lines show the inverse, not a held value
  assign smp = rec ? {4'h0, cnt[3:0]} : {4'hf, ~cnt[3:0]};
  assign vld = rec;
  assign trg = rec && (cnt >= 12'h834);
endmodule : csc_src_model
`default_nettype wire

// ---- tb/capture_search_compare_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module capture_search_compare_tb_top;
  logic               pclk, presetn, psel, penable, pwrite; // apb master side
  logic [7:0]         paddr;         // byte address
  logic [31:0]        pwdata, prdata, rd; // data, last read
  logic               pready, pslverr, se;    // answer, saved error
  logic [7:0]         smp;           // sample
  logic               vld, trg, rec, stp;     // source and status
  logic [10:0]        cur, vb;       // cursor, view base
  csc_pkg::csc_keys_t keys;          // panel keys, idle except one held step/compare/autostop burst
  csc_pkg::csc_view_t vw;            // word at cursor
  int                 num_errors, check_count; // tallies
  // rows: {search setup, expected match count} over 2000 words of a 16-step ramp
  logic [63:0] rows [6] = '{64'hff07_00ff_0000_0000, 64'hff07_0103_0000_00fa,
    64'hff00_0001_0000_03e8, 64'h0107_0001_0000_03e8, 64'hff03_000f_0000_007d,
    64'hff07_0003_0000_007d};
  // short key timing keeps held-key counts small
  csc_top #(.HOLD_CYC(40), .RPT_CYC(10)) csc_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(smp),
    .sample_valid(vld), .trigger(trg), .keys(keys), .cursor_o(cur), .view_base_o(vb),
    .view_o(vw), .recording_o(rec), .stopped_mm_o(stp));
  csc_src_model csc_src_model_inst (.pclk(pclk), .rec(rec), .smp(smp), .vld(vld), .trg(trg));
  // compare and tally
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: a hung slave is caught by the watchdog
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // poll state until the engine shows the given state
  task automatic till(input logic [2:0] s);
    do apb(1'b0, 8'h20, 32'h0);
    while (rd[2:0] !== s);
  endtask : till
  task automatic idle();
    till(3'h0);
  endtask : idle
  // four decimal digits then enter; view settles two cycles later
  task automatic jump(input logic [15:0] ds);
    for (int i = 3; i >= 0; i--) apb(1'b1, 8'h0c, {28'h0, ds[i*4+:4]});
    apb(1'b1, 8'h04, 32'h10);
    repeat (3) @(posedge pclk);
  endtask : jump
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // watchdog well beyond the roughly 50000 cycles that all passes take
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    keys = '0;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h04, 32'h1);
    idle();
    chk({21'h0, cur}, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, 8'h08, rows[i][63:32]);
      apb(1'b1, 8'h04, 32'h2);
      idle();
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, rows[i][31:0]);
      chk({31'h0, vw.match}, {31'h0, |rows[i][31:0]});
    end
    // display word i holds (i + 4) mod 16: word 3 sits at 15, 31, ... 1999
    chk({21'h0, cur}, 32'h1f);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h002f_000f);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h7cf);
    apb(1'b1, 8'h04, 32'h4);
    @(posedge pclk);
    chk({21'h0, cur}, 32'h2f);
    idle();
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h003f_000f);
    jump(16'h0123);
    chk({21'h0, cur}, 32'h7b);
    jump(16'h9999);
    chk({21'h0, cur}, 32'h7cf);
    apb(1'b1, 8'h04, 32'h8);
    idle();
    chk({21'h0, vb}, 32'h7bc);
    apb(1'b1, 8'h24, 32'h0005_00ff);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h1);
    idle();
    jump(16'h0005);
    chk({31'h0, vw.mismatch}, 32'h1);
    chk({24'h0, vw.data}, 32'h9);
    jump(16'h0006);
    chk({31'h0, vw.mismatch}, 32'h0);
    apb(1'b1, 8'h04, 32'h20);
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h04, 32'h40);
    @(posedge pclk);
    chk({21'h0, cur}, 32'h5);
    // held step key: one step on the press, then at 40, 50 and 60 cycles
    keys.step_up  <= 1'b1;
    keys.compare  <= 1'b1;
    keys.autostop <= 1'b1;
    repeat (65) @(posedge pclk);
    keys <= '0;
    chk({21'h0, cur}, 32'h9);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h04, 32'h1);
    idle();
    chk({30'h0, stp, rec}, 32'h2);
    // reference made equal again: the compare pass must lead back to capture
    apb(1'b1, 8'h24, 32'h0005_0009);
    apb(1'b1, 8'h04, 32'h1);
    till(3'h3);
    do apb(1'b0, 8'h20, 32'h0);
    while (rd[2:0] === 3'h3);
    chk({29'h0, rd[2:0]}, 32'h1);
    chk({31'h0, stp}, 32'h0);
    apb(1'b1, 8'h24, 32'h0005_00ff);
    idle();
    chk({30'h0, stp, rec}, 32'h2);
    jump(16'h0007);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, se}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'hff07_0000);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk({21'h0, cur}, 32'h0);
    // polarity chosen before the recording: display word 0 is ~8'h04
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h1);
    idle();
    @(posedge pclk);
    chk({24'h0, vw.data}, 32'hfb);
    close_out();
  end
endmodule : capture_search_compare_tb_top
`default_nettype wire
